// ### verilog/ode_cfg.svh
// Constants for the overheat diode emulation controller
`ifndef ODE_CFG_SVH
`define ODE_CFG_SVH

`define CLK_MHZ        100
`define BLANK_TIME_NS  200
`define BLANK_CYCLES   ((`BLANK_TIME_NS * `CLK_MHZ + 999) / 1000)
`define BLANK_CNT_W    8

// Positions of the asynchronous inputs in the synchroniser vector
`define SYNC_W         9
`define IN_CMD         0
`define IN_SUP_RISE    1
`define IN_SUP_FALL    2
`define IN_RAIL_5V     3
`define IN_RAIL_NEG    4
`define IN_OT_SWITCH   5
`define IN_OT_DRIVER   6
`define IN_DRAIN_NEG   7
`define IN_DRAIN_FWD   8

`endif

// ### verilog/ode_pkg.sv
// Types for the overheat diode emulation controller
package ode_pkg;
    // Gray order: normal, watch, conduct, blank
    typedef enum logic [1:0] {
        IDM_NORMAL  = 2'h0,
        IDM_WATCH   = 2'h1,
        IDM_CONDUCT = 2'h3,
        IDM_BLANK   = 2'h2
    } idm_state_t;

    typedef enum logic [1:0] {
        SU_WAIT  = 2'h0,
        SU_BUILD = 2'h1,
        SU_READY = 2'h3
    } startup_state_t;
endpackage

// ### verilog/startup_if.sv
// Carrier between the controller core and its start-up sequencer
`timescale 1ns/1ps
interface startup_if;
    logic supply_rise;
    logic supply_fall;
    logic rail_5v_ok;
    logic neg_rail_ok;
    logic rails_enable;
    logic ready;

    modport seq (
        input  supply_rise,
        input  supply_fall,
        input  rail_5v_ok,
        input  neg_rail_ok,
        output rails_enable,
        output ready
    );
    modport core (
        output supply_rise,
        output supply_fall,
        output rail_5v_ok,
        output neg_rail_ok,
        input  rails_enable,
        input  ready
    );
endinterface

// ### verilog/startup_seq.sv
// Power-up sequencer: supply threshold, rail build-up, ready flag
`timescale 1ns/1ps
`include "ode_cfg.svh"
module startup_seq (
    input  wire logic  clock,
    input  wire logic  rst_n,
    startup_if.seq     su
);
    import ode_pkg::*;

    startup_state_t state_reg;
    startup_state_t state_next;
    logic           rails_enable_reg;
    logic           rails_enable_next;
    logic           ready_reg;
    logic           ready_next;

    // Sequence: wait supply, build rails, ready; a dip restarts it
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SU_WAIT: begin
                if (su.supply_rise) begin
                    state_next = SU_BUILD;
                end
            end
            SU_BUILD: begin
                if (su.supply_fall) begin
                    state_next = SU_WAIT;
                end else if (su.rail_5v_ok && su.neg_rail_ok) begin
                    state_next = SU_READY;
                end
            end
            SU_READY: begin
                if (su.supply_fall) begin
                    state_next = SU_WAIT;
                end
            end
            default: state_next = SU_WAIT;
        endcase
        rails_enable_next = (state_next != SU_WAIT);
        ready_next        = (state_next == SU_READY);
    end

    // Reset leaves ready low, so the fault pin starts low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg        <= SU_WAIT;
            rails_enable_reg <= 1'b0;
            ready_reg        <= 1'b0;
        end else begin
            state_reg        <= state_next;
            rails_enable_reg <= rails_enable_next;
            ready_reg        <= ready_next;
        end
    end

    assign su.rails_enable = rails_enable_reg;
    assign su.ready        = ready_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_rails_on_rise;
        state_reg == SU_WAIT && su.supply_rise |=> rails_enable_reg;
    endproperty
    a_rails_on_rise: assert property (p_rails_on_rise)
        else $error("rails not enabled after supply rise");

    property p_build_halt;
        state_reg == SU_BUILD && su.supply_fall
            |=> state_reg == SU_WAIT && !rails_enable_reg;
    endproperty
    a_build_halt: assert property (p_build_halt)
        else $error("rail build not halted on supply dip");

    property p_ready_rails;
        state_reg == SU_BUILD && !su.supply_fall && su.rail_5v_ok
            && su.neg_rail_ok |=> ready_reg;
    endproperty
    a_ready_rails: assert property (p_ready_rails)
        else $error("ready not raised when both rails good");

    // Ready may only rise once both rails report good
    property p_not_ready_early;
        !ready_reg && !(su.rail_5v_ok && su.neg_rail_ok) |=> !ready_reg;
    endproperty
    a_not_ready_early: assert property (p_not_ready_early)
        else $error("ready high before rails are good");

    c_ready: cover property (state_reg == SU_BUILD ##1 ready_reg);
endmodule

// ### verilog/overheat_diode_emulation_ctrl.sv
// Overheat ideal-diode emulation state machine and fault output
`timescale 1ns/1ps
`include "ode_cfg.svh"
module overheat_diode_emulation_ctrl (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic cmd_in,
    input  wire logic supply_above_rise,
    input  wire logic supply_below_fall,
    input  wire logic rail_5v_ok,
    input  wire logic neg_rail_ok,
    input  wire logic switch_overheat,
    input  wire logic driver_overheat,
    input  wire logic drain_negative,
    input  wire logic drain_forward,
    output wire logic switch_on,
    output wire logic fault_n,
    output wire logic rails_enable,
    output ode_pkg::idm_state_t idm_state
);
    import ode_pkg::*;

    localparam logic [`BLANK_CNT_W-1:0] BLANK_LOAD =
        `BLANK_CNT_W'(`BLANK_CYCLES - 1);

    logic                    rst_meta_reg;
    logic                    rst_n;
    logic [`SYNC_W-1:0]      async_in;
    logic [`SYNC_W-1:0]      sync1_reg;
    logic [`SYNC_W-1:0]      sync2_reg;
    idm_state_t              state_reg;
    idm_state_t              state_next;
    logic [`BLANK_CNT_W-1:0] blank_cnt_reg;
    logic [`BLANK_CNT_W-1:0] blank_cnt_next;
    logic                    cmd_prev_reg;
    logic                    cmd_prev_next;
    logic                    switch_on_reg;
    logic                    switch_on_next;
    logic                    fault_n_reg;
    logic                    fault_n_next;
    logic                    cmd_s;
    logic                    ot_sw;
    logic                    ot_drv;
    logic                    shutdown;
    logic                    fall;
    logic                    ready;

    startup_if su ();

    // Falling edge seen between the previous and current command sample
    function automatic logic falling(input logic prev, input logic cur);
        return prev && !cur;
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    assign async_in = {drain_forward, drain_negative, driver_overheat,
                       switch_overheat, neg_rail_ok, rail_5v_ok,
                       supply_below_fall, supply_above_rise, cmd_in};

    // Every pin and comparator passes two flops before any logic
    genvar i;
    generate
        for (i = 0; i < `SYNC_W; i = i + 1) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= async_in[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    assign cmd_s    = sync2_reg[`IN_CMD];
    assign ot_sw    = sync2_reg[`IN_OT_SWITCH];
    assign ot_drv   = sync2_reg[`IN_OT_DRIVER];
    assign shutdown = ot_sw || ot_drv;
    assign fall     = falling(cmd_prev_reg, cmd_s);
    assign ready    = su.ready;

    assign su.supply_rise = sync2_reg[`IN_SUP_RISE];
    assign su.supply_fall = sync2_reg[`IN_SUP_FALL];
    assign su.rail_5v_ok  = sync2_reg[`IN_RAIL_5V];
    assign su.neg_rail_ok = sync2_reg[`IN_RAIL_NEG];

    startup_seq u_startup (
        .clock (clock),
        .rst_n (rst_n),
        .su    (su.seq)
    );

    // Next state of the emulation machine and its switch and fault pins
    always_comb begin
        state_next     = state_reg;
        blank_cnt_next = blank_cnt_reg;
        cmd_prev_next  = cmd_s;
        if (!ready || !shutdown) begin
            state_next = IDM_NORMAL;
        end else if (ot_drv) begin
            // Driver too hot: park off in watch, resume when it cools
            state_next = IDM_WATCH;
        end else if (fall) begin
            // No count or lockout: a weak partner must not be starved
            state_next     = IDM_BLANK;
            blank_cnt_next = BLANK_LOAD;
        end else begin
            case (state_reg)
                IDM_NORMAL: state_next = IDM_WATCH;
                IDM_BLANK: begin
                    // Fixed time only; a missing drain rise cannot hang
                    if (blank_cnt_reg == '0) begin
                        state_next = IDM_WATCH;
                    end else begin
                        blank_cnt_next = blank_cnt_reg - 1'b1;
                    end
                end
                IDM_WATCH: begin
                    if (sync2_reg[`IN_DRAIN_NEG]) begin
                        state_next = IDM_CONDUCT;
                    end
                end
                IDM_CONDUCT: begin
                    if (sync2_reg[`IN_DRAIN_FWD]) begin
                        state_next = IDM_WATCH;
                    end
                end
                default: state_next = IDM_WATCH;
            endcase
        end
        // Only conduct turns the switch on while in shutdown
        switch_on_next = ready && ((state_next == IDM_NORMAL && cmd_s)
                         || state_next == IDM_CONDUCT);
        fault_n_next   = ready && !shutdown;
    end

    // Registers only; fault starts low so the pin is low at power-up
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= IDM_NORMAL;
            blank_cnt_reg <= '0;
            cmd_prev_reg  <= 1'b0;
            switch_on_reg <= 1'b0;
            fault_n_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            blank_cnt_reg <= blank_cnt_next;
            cmd_prev_reg  <= cmd_prev_next;
            switch_on_reg <= switch_on_next;
            fault_n_reg   <= fault_n_next;
        end
    end

    assign switch_on    = switch_on_reg;
    assign fault_n      = fault_n_reg;
    assign rails_enable = su.rails_enable;
    assign idm_state    = state_reg;

    // Helper: cycles spent in blanking, for the fixed-length check
    logic [`BLANK_CNT_W-1:0] blank_age_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blank_age_reg <= '0;
        end else if (state_next == IDM_BLANK && state_reg == IDM_BLANK
                     && !fall) begin
            blank_age_reg <= blank_age_reg + 1'b1;
        end else begin
            blank_age_reg <= '0;
        end
    end

    logic idm_run;
    assign idm_run = ready && ot_sw && !ot_drv;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_fall_blank;
        idm_run && fall |=> state_reg == IDM_BLANK && !switch_on_reg;
    endproperty
    a_fall_blank: assert property (p_fall_blank)
        else $error("falling edge did not enter blanking");

    property p_blank_end;
        idm_run && !fall && state_reg == IDM_BLANK && blank_cnt_reg == '0
            |=> state_reg == IDM_WATCH;
    endproperty
    a_blank_end: assert property (p_blank_end)
        else $error("blanking did not end at zero count");

    property p_blank_len;
        state_reg == IDM_BLANK |-> blank_age_reg < `BLANK_CYCLES;
    endproperty
    a_blank_len: assert property (p_blank_len)
        else $error("blanking longer than fixed interval");

    property p_watch_off;
        state_reg == IDM_WATCH || state_reg == IDM_BLANK |-> !switch_on_reg;
    endproperty
    a_watch_off: assert property (p_watch_off)
        else $error("switch on in blanking or watch");

    property p_neg_conduct;
        idm_run && !fall && state_reg == IDM_WATCH
            && sync2_reg[`IN_DRAIN_NEG] |=> state_reg == IDM_CONDUCT
            && switch_on_reg;
    endproperty
    a_neg_conduct: assert property (p_neg_conduct)
        else $error("negative drain did not start conduction");

    property p_fwd_watch;
        idm_run && !fall && state_reg == IDM_CONDUCT
            && sync2_reg[`IN_DRAIN_FWD] |=> state_reg == IDM_WATCH
            && !switch_on_reg;
    endproperty
    a_fwd_watch: assert property (p_fwd_watch)
        else $error("forward current did not stop conduction");

    property p_enter_watch;
        idm_run && !fall && state_reg == IDM_NORMAL |=> state_reg == IDM_WATCH;
    endproperty
    a_enter_watch: assert property (p_enter_watch)
        else $error("shutdown did not start in watch");

    property p_no_edge_no_blank;
        state_reg != IDM_BLANK && !fall |=> state_reg != IDM_BLANK;
    endproperty
    a_no_edge_no_blank: assert property (p_no_edge_no_blank)
        else $error("blanking entered without command edge");

    property p_fault_low;
        shutdown |=> !fault_n_reg;
    endproperty
    a_fault_low: assert property (p_fault_low)
        else $error("fault pin high during overheat");

    property p_fault_release;
        ready && !shutdown |=> fault_n_reg && state_reg == IDM_NORMAL;
    endproperty
    a_fault_release: assert property (p_fault_release)
        else $error("fault not released after cool down");

    c_blank_pass: cover property (state_reg == IDM_BLANK ##[1:40]
                                  state_reg == IDM_WATCH);
    c_conduct: cover property (state_reg == IDM_CONDUCT ##[1:20]
                               state_reg == IDM_WATCH);
    c_resume: cover property (ready && ot_drv ##1 idm_run);
endmodule

// ### sim/conv_ctrl_model.sv
// Behavioural converter controller that drives the switch command pin
`timescale 1ns/1ps
module conv_ctrl_model (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output wire logic       cmd_in,
    output wire logic       busy
);
    logic       cmd_reg;
    logic       cmd_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    // One high pulse of len cycles; its falling edge is what the device sees
    always_comb begin
        cmd_next = cmd_reg;
        cnt_next = cnt_reg;
        if (go && cnt_reg == 8'h00) begin
            cmd_next = 1'b1; // Toggle this device first on start
            cnt_next = len;
        end else if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
                cmd_next = 1'b0;
            end
        end
    end

    // Command idles low so a restart can never shoot through
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else begin
            cmd_reg <= cmd_next;
            cnt_reg <= cnt_next;
        end
    end

    assign cmd_in = cmd_reg;
    assign busy   = (cnt_reg != 8'h00);
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the overheat diode emulation controller
`timescale 1ns/1ps
`include "ode_cfg.svh"
module tb_top;
    import ode_pkg::*;
    logic       clock;
    logic       nrst;
    logic       cmd_in;
    logic       sup_rise;
    logic       sup_fall;
    logic       ok_5v;
    logic       ok_neg;
    logic       ot_sw;
    logic       ot_drv;
    logic       drn_neg;
    logic       drn_fwd;
    logic       go;
    logic [7:0] len;
    logic       switch_on;
    logic       fault_n;
    logic       rails_enable;
    idm_state_t idm_state;
    int         mismatches;
    int         check_count;

    overheat_diode_emulation_ctrl dut (
        .clock(clock), .nrst(nrst), .cmd_in(cmd_in),
        .supply_above_rise(sup_rise), .supply_below_fall(sup_fall),
        .rail_5v_ok(ok_5v), .neg_rail_ok(ok_neg),
        .switch_overheat(ot_sw), .driver_overheat(ot_drv),
        .drain_negative(drn_neg), .drain_forward(drn_fwd),
        .switch_on(switch_on), .fault_n(fault_n),
        .rails_enable(rails_enable), .idm_state(idm_state)
    );

    conv_ctrl_model partner (
        .clock(clock), .nrst(nrst), .go(go), .len(len),
        .cmd_in(cmd_in), .busy()
    );

    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic check_state(input string nm, input idm_state_t e);
        check_count++;
        if (idm_state !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, idm_state);
        end
    endtask

    task automatic check_cnt(input string nm, input int e, input int g);
        check_count++;
        if (g != e) begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Ask the partner for one command pulse of n cycles
    task automatic pulse(input logic [7:0] n);
        @(posedge clock);
        go  <= 1'b1;
        len <= n;
        @(posedge clock);
        go  <= 1'b0;
    endtask

    // Bounded wait for blanking; the machine may take a few edges to react
    task automatic wait_blank();
        for (int i = 0; i < 12 && idm_state !== IDM_BLANK; i++) step(1);
        check_state("blank entered", IDM_BLANK);
    endtask

    task automatic t_startup();
        @(posedge clock);
        ok_5v  <= 1'b1;
        ok_neg <= 1'b1;
        step(6);
        check_bit("rails before rise", 1'b0, rails_enable);
        check_bit("fault before rise", 1'b0, fault_n);
        @(posedge clock);
        ok_5v    <= 1'b0;
        ok_neg   <= 1'b0;
        sup_rise <= 1'b1;
        sup_fall <= 1'b0;
        step(4);
        check_bit("rails after rise", 1'b1, rails_enable);
        @(posedge clock);
        ok_5v <= 1'b1;
        step(6);
        check_bit("fault one rail", 1'b0, fault_n);
        // Dip below the falling threshold in mid build-up
        @(posedge clock);
        sup_rise <= 1'b0;
        sup_fall <= 1'b1;
        ok_neg   <= 1'b1;
        step(4);
        check_bit("rails in dip", 1'b0, rails_enable);
        step(4);
        check_bit("fault in dip", 1'b0, fault_n);
        @(posedge clock);
        sup_rise <= 1'b1;
        sup_fall <= 1'b0;
        step(8);
        check_bit("rails resumed", 1'b1, rails_enable);
        check_bit("fault released", 1'b1, fault_n);
        check_state("state normal", IDM_NORMAL);
    endtask

    task automatic t_follow();
        pulse(8'h0A);
        step(5);
        check_bit("switch follows high", 1'b1, switch_on);
        step(10);
        check_bit("switch follows low", 1'b0, switch_on);
    endtask

    // Shutdown entry and plain ideal-diode cycling without command edges
    task automatic t_shutdown();
        @(posedge clock);
        ot_sw <= 1'b1;
        step(4);
        check_state("entry state", IDM_WATCH);
        check_bit("fault in shutdown", 1'b0, fault_n);
        check_bit("entry switch", 1'b0, switch_on);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            drn_neg <= 1'b1;
            step(4);
            check_state("conduct", IDM_CONDUCT);
            check_bit("conduct switch", 1'b1, switch_on);
            @(posedge clock);
            drn_neg <= 1'b0;
            drn_fwd <= 1'b1;
            step(4);
            check_state("back to watch", IDM_WATCH);
            check_bit("watch switch", 1'b0, switch_on);
            @(posedge clock);
            drn_fwd <= 1'b0;
        end
    endtask

    // Falling edge from conduct; drain stays negative, blanking must not wait
    task automatic t_blank();
        int  n;
        logic on_seen;
        n = 0;
        on_seen = 1'b0;
        @(posedge clock);
        drn_neg <= 1'b1;
        step(4);
        check_state("pre blank conduct", IDM_CONDUCT);
        pulse(8'h02);
        wait_blank();
        while (idm_state === IDM_BLANK && n < 60) begin
            if (switch_on !== 1'b0) on_seen = 1'b1;
            step(1);
            n++;
        end
        check_bit("switch in blank", 1'b0, on_seen);
        check_cnt("blank length", `BLANK_CYCLES, n);
    endtask

    // A second edge in mid blanking restarts the interval
    task automatic t_repeat();
        pulse(8'h02);
        wait_blank();
        step(6);
        pulse(8'h02);
        step(`BLANK_CYCLES - 8);
        check_state("blank restarted", IDM_BLANK);
        for (int i = 0; i < 40 && idm_state === IDM_BLANK; i++) step(1);
        // Blanking always lands in watch; drain is still negative, so the
        // machine moves on to conduct one edge later
        check_state("after second blank", IDM_WATCH);
        step(1);
        check_state("conduct after watch", IDM_CONDUCT);
    endtask

    task automatic t_driver();
        @(posedge clock);
        ot_drv <= 1'b1;
        step(4);
        check_state("driver hot", IDM_WATCH);
        check_bit("driver hot switch", 1'b0, switch_on);
        pulse(8'h02);
        step(6);
        check_state("edge ignored", IDM_WATCH);
        @(posedge clock);
        ot_drv <= 1'b0;
        step(4);
        check_state("resumed", IDM_CONDUCT);
        check_bit("fault while hot", 1'b0, fault_n);
    endtask

    task automatic t_cool();
        @(posedge clock);
        ot_drv  <= 1'b1;
        ot_sw   <= 1'b0;
        drn_neg <= 1'b0;
        step(4);
        check_bit("fault driver hot", 1'b0, fault_n);
        @(posedge clock);
        ot_drv <= 1'b0;
        step(4);
        check_bit("fault cooled", 1'b1, fault_n);
        check_state("cooled state", IDM_NORMAL);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Reset with the supply low and every input at rest
    initial begin
        mismatches  = 0;
        check_count = 0;
        nrst     = 1'b0;
        sup_rise = 1'b0;
        sup_fall = 1'b1;
        ok_5v    = 1'b0;
        ok_neg   = 1'b0;
        ot_sw    = 1'b0;
        ot_drv   = 1'b0;
        drn_neg  = 1'b0;
        drn_fwd  = 1'b0;
        go       = 1'b0;
        len      = 8'h00;
        step(16);
        check_bit("reset fault", 1'b0, fault_n);
        check_bit("reset switch", 1'b0, switch_on);
        check_bit("reset rails", 1'b0, rails_enable);
        check_state("reset state", IDM_NORMAL);
        @(posedge clock);
        nrst <= 1'b1;
        step(3);
        t_startup();
        t_follow();
        t_shutdown();
        t_blank();
        t_repeat();
        t_driver();
        t_cool();
        end_sim();
    end

    // Whole run is well under 1000 cycles; this cuts a hang short
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule
